// [inc/angc_pkg.sv]
// package: register map, field positions, reset values and modes of the autoneg page block
`default_nettype none
package angc_pkg;
    // register indices as printed; byte address is four times the index
    localparam logic [7:0] IDX_EXPANSION = 8'h06;
    localparam logic [7:0] IDX_NP_TX = 8'h07;
    localparam logic [7:0] IDX_NP_RX = 8'h08;
    localparam logic [7:0] IDX_GIG_CTRL = 8'h09;
    localparam int ADDR_LSB = 2;
    // expansion status bits
    localparam int EXP_PAR_FAULT = 4;
    localparam int EXP_LP_NP_ABLE = 3;
    localparam int EXP_NP_ABLE = 2;
    localparam int EXP_PAGE_RX = 1;
    localparam int EXP_LP_AN_ABLE = 0;
    localparam logic LOCAL_NP_ABLE = 1'b1;
    // next page field positions (shared by tx and rx words)
    localparam int NP_MORE = 15;
    localparam int NP_ACK = 14;
    localparam int NP_MSG = 13;
    localparam int NP_ACK2 = 12;
    localparam int NP_TOGGLE = 11;
    localparam int NP_CODE_HI = 10;
    localparam logic [15:0] NP_TX_RESET = 16'h2001;
    localparam logic [15:0] NP_TX_WMASK = 16'hB7FF;
    localparam logic [15:0] NP_RX_MASK = 16'hFFFF;
    // gigabit control field positions
    localparam int GC_TEST_HI = 15;
    localparam int GC_TEST_LO = 13;
    localparam int GC_MS_MAN_EN = 12;
    localparam int GC_MS_MAN_VAL = 11;
    localparam int GC_PORT_TYPE = 10;
    localparam int GC_FD = 9;
    localparam int GC_HD = 8;
    localparam logic [15:0] GC_RESET = 16'h0300;
    localparam logic [15:0] GC_WMASK = 16'hFF00;
    // transmitter test modes
    typedef enum logic [2:0] {
        ANGC_TM_NORMAL = 3'b000,
        ANGC_TM_WAVEFORM = 3'b001,
        ANGC_TM_JIT_MASTER = 3'b010,
        ANGC_TM_JIT_SLAVE = 3'b011,
        ANGC_TM_DISTORT = 3'b100
    } angc_test_mode_t;
endpackage
`default_nettype wire

// [logic/angc_regs.sv]
// autoneg expansion, next page tx/rx and gigabit control registers over apb
// Functional notes
// - parallel detection fault latches high, reset 0
// - bit 3 shows partner next page ability
// - bit 2 reports local next page, reads 1
// - page received latches high, reset 0
// - bit 0 shows partner autoneg ability
// - tx next page writable more, msg, code
// - tx toggle inverts previous sent toggle
// - tx acknowledge-comply bit writable, reset 0
// - received partner next page read-only, reset 0
// - partner ack bit set once word received
// - partner comply acknowledge shown read-only
// - test mode selects transmitter behaviour
// - manual master/slave enable overrides resolution
// - manual value picks master or slave
// - port type bit, multi or single
// - advertise gigabit full duplex, default 1
// - advertise gigabit half duplex, default 1
`timescale 1ns/10ps
`default_nettype none
module angc_regs (
    input wire logic sys_clk_in, // 20 mhz system clock
    input wire logic rst_in, // synchronous active high reset
    input wire logic psel_in, // apb select
    input wire logic penable_in, // apb access phase
    input wire logic pwrite_in, // apb direction, 1 write
    input wire logic [11:0] paddr_in, // apb byte address
    input wire logic [31:0] pwdata_in, // apb write data
    output logic [31:0] prdata_out, // apb read data
    output logic pready_out, // apb ready
    output logic pslverr_out, // apb error on unmapped address
    input wire logic par_fault_evt_in, // parallel detection fault, level or pulse
    input wire logic page_rx_evt_in, // one-cycle pulse, partner word received
    input wire logic [15:0] page_rx_word_in, // received partner link_code_word
    input wire logic lp_an_able_in, // partner has autoneg ability
    input wire logic lp_np_able_in, // partner has next page ability
    input wire logic page_tx_evt_in, // one-cycle pulse, our word sent
    output logic [15:0] np_tx_word_out, // outgoing next page word
    output logic [2:0] test_mode_out, // transmitter test mode, reserved forced normal
    output logic ms_manual_out, // manual master/slave in force
    output logic ms_master_out, // manual value: 1 master
    output logic port_multi_out, // port type advertised
    output logic adv_1000_fd_out, // advertise 1000 full duplex
    output logic adv_1000_hd_out // advertise 1000 half duplex
);
    // register state
    logic par_fault_q, par_fault_d; // latched fault
    logic page_rx_q, page_rx_d; // latched page received
    logic [15:0] np_tx_q, np_tx_d; // outgoing next page
    logic [15:0] np_rx_q, np_rx_d; // received partner page
    logic [15:0] gc_q, gc_d; // gigabit control
    logic [31:0] prdata_q, prdata_d; // read data register
    logic pready_q, pready_d; // ready register
    logic pslverr_q, pslverr_d; // error register
    logic [2:0] tm_q, tm_d; // decoded test mode
    logic ms_man_q, ms_man_d; // manual master/slave
    logic ms_val_q, ms_val_d; // manual value gated
    logic [15:0] np_tx_o_q, np_tx_o_d; // registered word out

    // bus decode
    logic setup; // first access-phase cycle seen (one wait state before ready)
    logic access; // transfer completes this edge
    logic [7:0] idx; // register index

    // word index from byte address
    function automatic logic [7:0] word_idx(input logic [11:0] a);
        word_idx = a[9:angc_pkg::ADDR_LSB];
    endfunction

    // masked write keeps read-only bits
    function automatic logic [15:0] mwrite(input logic [15:0] old, input logic [15:0] wd,
                                           input logic [15:0] m);
        mwrite = (old & ~m) | (wd & m);
    endfunction

    assign idx = word_idx(paddr_in);
    assign setup = psel_in && penable_in && !pready_q;
    assign access = psel_in && penable_in && pready_q;

    // next state of registers and bus answer
    always_comb begin
        logic [15:0] exp_v;
        exp_v = 16'h0000;
        par_fault_d = par_fault_q;
        page_rx_d = page_rx_q;
        np_tx_d = np_tx_q;
        np_rx_d = np_rx_q;
        gc_d = gc_q;
        prdata_d = prdata_q;
        pready_d = 1'b0;
        pslverr_d = 1'b0;
        // read value of expansion status, reserved bits zero
        exp_v[angc_pkg::EXP_PAR_FAULT] = par_fault_q;
        exp_v[angc_pkg::EXP_LP_NP_ABLE] = lp_np_able_in;
        exp_v[angc_pkg::EXP_NP_ABLE] = angc_pkg::LOCAL_NP_ABLE;
        exp_v[angc_pkg::EXP_PAGE_RX] = page_rx_q;
        exp_v[angc_pkg::EXP_LP_AN_ABLE] = lp_an_able_in;
        // ready one cycle into the access phase, answer data prepared then
        if (setup) begin
            pready_d = 1'b1;
            case (idx)
                angc_pkg::IDX_EXPANSION: prdata_d = {16'h0000, exp_v};
                angc_pkg::IDX_NP_TX: prdata_d = {16'h0000, np_tx_q};
                angc_pkg::IDX_NP_RX: prdata_d = {16'h0000, np_rx_q};
                angc_pkg::IDX_GIG_CTRL: prdata_d = {16'h0000, gc_q};
                default: prdata_d = 32'h0000_0000;
            endcase
            pslverr_d = !(idx == angc_pkg::IDX_EXPANSION || idx == angc_pkg::IDX_NP_TX ||
                          idx == angc_pkg::IDX_NP_RX || idx == angc_pkg::IDX_GIG_CTRL) ||
                        (paddr_in[11:10] != 2'b00);
        end
        // read of expansion clears latched bits; a new event the same edge wins
        // only a bit that the answer reported is cleared, so an event that lands after
        // the data was captured is not lost unseen
        if (access && !pwrite_in && idx == angc_pkg::IDX_EXPANSION) begin
            if (prdata_q[angc_pkg::EXP_PAR_FAULT]) begin
                par_fault_d = 1'b0;
            end
            if (prdata_q[angc_pkg::EXP_PAGE_RX]) begin
                page_rx_d = 1'b0;
            end
        end
        if (par_fault_evt_in) begin
            par_fault_d = 1'b1;
        end
        if (page_rx_evt_in) begin
            page_rx_d = 1'b1;
            np_rx_d = page_rx_word_in & angc_pkg::NP_RX_MASK;
            // a word has arrived, so the partner acknowledge bit reads 1
            np_rx_d[angc_pkg::NP_ACK] = 1'b1;
        end
        // software writes, read-only bits masked off
        if (access && pwrite_in && !pslverr_q) begin
            case (idx)
                angc_pkg::IDX_NP_TX: np_tx_d = mwrite(np_tx_q, pwdata_in[15:0],
                                                      angc_pkg::NP_TX_WMASK);
                angc_pkg::IDX_GIG_CTRL: gc_d = mwrite(gc_q, pwdata_in[15:0],
                                                      angc_pkg::GC_WMASK);
                default: gc_d = gc_q;
            endcase
        end
        // toggle holds inverse of the toggle just sent
        if (page_tx_evt_in) begin
            np_tx_d[angc_pkg::NP_TOGGLE] = ~np_tx_q[angc_pkg::NP_TOGGLE];
        end
    end

    // next state of the control outputs
    always_comb begin
        tm_d = gc_q[angc_pkg::GC_TEST_HI:angc_pkg::GC_TEST_LO];
        // reserved codes are treated as normal so the transmitter never sees them
        case (gc_q[angc_pkg::GC_TEST_HI:angc_pkg::GC_TEST_LO])
            angc_pkg::ANGC_TM_NORMAL,
            angc_pkg::ANGC_TM_WAVEFORM,
            angc_pkg::ANGC_TM_JIT_MASTER,
            angc_pkg::ANGC_TM_JIT_SLAVE,
            angc_pkg::ANGC_TM_DISTORT: tm_d = gc_q[angc_pkg::GC_TEST_HI:angc_pkg::GC_TEST_LO];
            default: tm_d = angc_pkg::ANGC_TM_NORMAL;
        endcase
        ms_man_d = gc_q[angc_pkg::GC_MS_MAN_EN];
        // value only meaningful while manual enable is set
        ms_val_d = gc_q[angc_pkg::GC_MS_MAN_EN] & gc_q[angc_pkg::GC_MS_MAN_VAL];
        np_tx_o_d = np_tx_q;
    end

    // register everything
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            par_fault_q <= 1'b0;
            page_rx_q <= 1'b0;
            np_tx_q <= angc_pkg::NP_TX_RESET;
            np_rx_q <= 16'h0000;
            gc_q <= angc_pkg::GC_RESET;
            prdata_q <= 32'h0000_0000;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            tm_q <= 3'b000;
            ms_man_q <= 1'b0;
            ms_val_q <= 1'b0;
            np_tx_o_q <= angc_pkg::NP_TX_RESET;
        end else begin
            par_fault_q <= par_fault_d;
            page_rx_q <= page_rx_d;
            np_tx_q <= np_tx_d;
            np_rx_q <= np_rx_d;
            gc_q <= gc_d;
            prdata_q <= prdata_d;
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
            tm_q <= tm_d;
            ms_man_q <= ms_man_d;
            ms_val_q <= ms_val_d;
            np_tx_o_q <= np_tx_o_d;
        end
    end

    // outputs straight from flops
    assign prdata_out = prdata_q;
    assign pready_out = pready_q;
    assign pslverr_out = pslverr_q;
    assign np_tx_word_out = np_tx_o_q;
    assign test_mode_out = tm_q;
    assign ms_manual_out = ms_man_q;
    assign ms_master_out = ms_val_q;
    assign port_multi_out = gc_q[angc_pkg::GC_PORT_TYPE];
    assign adv_1000_fd_out = gc_q[angc_pkg::GC_FD];
    assign adv_1000_hd_out = gc_q[angc_pkg::GC_HD];
endmodule
`default_nettype wire

// [tb/angc_sva.sv]
// checker: apb timing and field relations at the register block ports
`timescale 1ns/10ps
`default_nettype none
module angc_sva (
    input wire logic sys_clk_in, // clock
    input wire logic rst_in, // reset
    input wire logic psel_in, // select
    input wire logic penable_in, // access
    input wire logic pwrite_in, // direction
    input wire logic [11:0] paddr_in, // address
    input wire logic [31:0] prdata_out, // read data
    input wire logic pready_out, // ready
    input wire logic par_fault_evt_in, // fault
    input wire logic page_rx_evt_in, // page in
    input wire logic lp_an_able_in, // partner an
    input wire logic lp_np_able_in, // partner np
    input wire logic page_tx_evt_in, // page out
    input wire logic [15:0] np_tx_word_out, // tx word
    input wire logic [2:0] test_mode_out, // mode
    input wire logic ms_manual_out, // manual on
    input wire logic ms_master_out, // master
    input wire logic adv_1000_fd_out, // fd
    input wire logic adv_1000_hd_out // hd
);
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (rst_in);
    // expansion read whose data is on the bus now
    logic exp_rd;
    assign exp_rd = pready_out && !pwrite_in && paddr_in == 12'h018;
    // one wait state, then a single-cycle ready
    property p_wait; psel_in && penable_in && !pready_out |=> pready_out ##1 !pready_out; endproperty
    a_wait: assert property (p_wait) else $error("ready timing wrong");
    property p_live; exp_rd |-> prdata_out[2] && prdata_out[0] == $past(lp_an_able_in)
        && prdata_out[3] == $past(lp_np_able_in); endproperty
    a_live: assert property (p_live) else $error("expansion flags wrong");
    property p_flt; exp_rd && $past(par_fault_evt_in, 2) |-> prdata_out[4]; endproperty
    a_flt: assert property (p_flt) else $error("fault not latched");
    property p_pg; exp_rd && $past(page_rx_evt_in, 2) |-> prdata_out[1]; endproperty
    a_pg: assert property (p_pg) else $error("page received not latched");
    property p_tgl; page_tx_evt_in |-> ##2 np_tx_word_out[11] != $past(np_tx_word_out[11], 2);
    endproperty
    a_tgl: assert property (p_tgl) else $error("toggle did not flip");
    property p_ms; ms_master_out |-> ms_manual_out; endproperty
    a_ms: assert property (p_ms) else $error("master value without enable");
    property p_tm; test_mode_out[2] |-> test_mode_out[1:0] == 2'b00; endproperty
    a_tm: assert property (p_tm) else $error("reserved test mode driven");
    property p_rst; $fell(rst_in) |-> adv_1000_fd_out && adv_1000_hd_out
        && np_tx_word_out == 16'h2001; endproperty
    a_rst: assert property (p_rst) else $error("reset values wrong");
endmodule
`default_nettype wire

// [tb/angc_lp_model.sv]
// link partner model: delivers received next pages as a strobe plus word
`timescale 1ns/10ps
`default_nettype none
module angc_lp_model (
    input wire logic sys_clk_in, // clock
    input wire logic send_in, // bench asks for one page
    input wire logic [15:0] page_in, // page to deliver
    output logic evt_out, // one-cycle page strobe
    output logic [15:0] word_out // page bus
);
    initial begin
        evt_out = 1'b0;
        word_out = 16'h0000;
    end
    // outside the strobe the bus flips each cycle so stale data is never mistaken for a page
    always @(posedge sys_clk_in) begin
        evt_out <= send_in;
        word_out <= send_in ? page_in : ~word_out;
    end
endmodule
`default_nettype wire

// [tb/tb_top.sv]
// testbench: drives the register block over apb beside a link partner model
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic sys_clk_in = 1'b0, rst_in = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic flt = 1'b0, tx = 1'b0, send = 1'b0, an = 1'b0, np = 1'b0, evt, pready, perr;
    logic mm, mv, pm, fd, hd;
    logic [11:0] paddr = 12'h000;
    logic [15:0] page = 16'h0000, word, ntw;
    logic [31:0] pwdata = 32'h0000_0000, prdata;
    logic [2:0] tm;
    int mismatches = 0, n_tests = 0, cyc = 0;
    angc_lp_model angc_lp_model_inst (.sys_clk_in(sys_clk_in), .send_in(send), .page_in(page),
        .evt_out(evt), .word_out(word));
    angc_regs angc_regs_inst (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .psel_in(psel),
        .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
        .prdata_out(prdata), .pready_out(pready), .pslverr_out(perr), .par_fault_evt_in(flt),
        .page_rx_evt_in(evt), .page_rx_word_in(word), .lp_an_able_in(an), .lp_np_able_in(np),
        .page_tx_evt_in(tx), .np_tx_word_out(ntw), .test_mode_out(tm), .ms_manual_out(mm),
        .ms_master_out(mv), .port_multi_out(pm), .adv_1000_fd_out(fd), .adv_1000_hd_out(hd));
    initial forever #25 sys_clk_in = ~sys_clk_in;
    task automatic chk(input logic [31:0] e, input logic [31:0] g, input string nm);
        n_tests++;
        if (g !== e) begin
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
            mismatches++;
        end
    endtask
    // one apb transfer; request held until ready is sampled high
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
        input logic [31:0] e, input logic ee);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk_in);
        penable <= 1'b1;
        @(posedge sys_clk_in iff pready === 1'b1);
        if (!w) chk(e, prdata, "read data");
        chk({31'h0, ee}, {31'h0, perr}, "error");
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk_in);
    endtask
    // one-cycle strobe: 0 sends our page, otherwise the partner delivers one
    task automatic pulse(input int which);
        if (which == 0) begin
            tx <= 1'b1;
        end else begin
            send <= 1'b1;
        end
        @(posedge sys_clk_in);
        tx <= 1'b0;
        send <= 1'b0;
        repeat (3) @(posedge sys_clk_in);
    endtask
    task automatic s_reset;
        xfer(0, 12'h018, 0, 32'h0000_0004, 0);
        xfer(0, 12'h01C, 0, 32'h0000_2001, 0);
        xfer(0, 12'h020, 0, 32'h0000_0000, 0);
        xfer(0, 12'h024, 0, 32'h0000_0300, 0);
        xfer(0, 12'h028, 0, 32'h0000_0000, 1);
        chk({fd, hd, mm, pm}, 4'b1100, "gig outputs");
    endtask
    task automatic s_tx;
        xfer(1, 12'h01C, 32'h0000_FFFF, 0, 0);
        xfer(0, 12'h01C, 0, 32'h0000_B7FF, 0);
        pulse(0);
        xfer(0, 12'h01C, 0, 32'h0000_BFFF, 0);
        chk({16'h0, ntw}, 32'h0000_BFFF, "tx word out");
    endtask
    task automatic s_rx;
        an <= 1'b1;
        np <= 1'b1;
        page <= 16'h1ABC;
        pulse(1);
        xfer(0, 12'h018, 0, 32'h0000_000F, 0);
        xfer(0, 12'h018, 0, 32'h0000_000D, 0);
        xfer(1, 12'h020, 32'h0000_FFFF, 0, 0);
        xfer(0, 12'h020, 0, 32'h0000_5ABC, 0);
        // fault held through a read: set wins over the clear of that read
        flt <= 1'b1;
        xfer(0, 12'h018, 0, 32'h0000_001D, 0);
        flt <= 1'b0;
        xfer(0, 12'h018, 0, 32'h0000_001D, 0);
        xfer(0, 12'h018, 0, 32'h0000_000D, 0);
    endtask
    // every test mode code, with the other control bits varied alongside
    task automatic s_gig;
        logic [15:0] v;
        for (int i = 0; i < 8; i++) begin
            v = {i[2:0], i[0], i[1], i[2], i[0], ~i[0], 8'hFF};
            xfer(1, 12'h024, {16'h0, v}, 0, 0);
            xfer(0, 12'h024, 0, {16'h0, v[15:8], 8'h00}, 0);
            chk({tm, mm, mv, pm, fd, hd}, {(i < 5) ? i[2:0] : 3'b000, i[0], i[0] & i[1],
                i[2], i[0], ~i[0]}, "gig outputs");
        end
    endtask
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // a hang is cut short well past the expected hundred and fifty or so cycles
    always @(posedge sys_clk_in) begin
        cyc++;
        if (cyc == 3000) begin
            mismatches++;
            report_and_stop();
        end
    end
    initial begin
        repeat (12) @(posedge sys_clk_in);
        rst_in <= 1'b0;
        @(posedge sys_clk_in);
        s_reset();
        s_tx();
        s_rx();
        s_gig();
        report_and_stop();
    end
endmodule
bind angc_regs angc_sva angc_sva_inst (.sys_clk_in, .rst_in, .psel_in, .penable_in, .pwrite_in,
    .paddr_in, .prdata_out, .pready_out, .par_fault_evt_in, .page_rx_evt_in, .lp_an_able_in,
    .lp_np_able_in, .page_tx_evt_in, .np_tx_word_out, .test_mode_out, .ms_manual_out,
    .ms_master_out, .adv_1000_fd_out, .adv_1000_hd_out);
`default_nettype wire
